// file: core/brg_pkg.sv
// package: constants, register map and carrier types of the board reset generator
package brg_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ         = 20_000_000;  // board clock rate
   localparam int unsigned RESET_MS       = 200;         // stretch time in ms
   localparam int unsigned RESET_CYCLES   = (CLK_HZ / 1000) * RESET_MS; // 4,000,000 cycles

   // register map, word offsets on the plain port
   localparam logic [3:0] ADDR_MCR        = 4'h0;  // memory_configuration_register
   localparam logic [3:0] ADDR_STATUS     = 4'h1;  // board_status_register
   localparam logic [3:0] ADDR_BP_CTRL    = 4'h2;  // backplane_reset_control_register

   // memory_configuration_register fields
   localparam int unsigned MCR_SW_RESET_BIT = 0;   // software_reset_request_bit, self clearing
   // board_status_register fields
   localparam int unsigned ST_WDOG_BIT      = 0;   // watchdog_reset_flag, write 1 to clear
   localparam int unsigned ST_RESET_BIT     = 1;   // board reset currently active
   localparam int unsigned ST_BOOT_BIT      = 2;   // boot memory mapped at zero
   localparam int unsigned ST_LOCK_BIT      = 3;   // processor lockout active
   localparam int unsigned ST_BPOUT_BIT     = 4;   // backplane reset output asserted
   // backplane_reset_control_register fields
   localparam int unsigned BP_INSTR_EN_BIT  = 0;   // instruction reset drives backplane

   // reset values
   localparam logic [7:0] BP_CTRL_RESET   = 8'h00;
   localparam logic [7:0] DATA_ZERO       = 8'h00;

   // boot vectors answered at address zero and four
   localparam logic [31:0] VEC_ADDR_ISP   = 32'h0000_0000; // initial_stack_pointer
   localparam logic [31:0] VEC_ADDR_IPC   = 32'h0000_0004; // initial_program_counter

   // synchronised event group from the pins
   typedef struct packed {
      logic volt_low;   // supply below threshold
      logic key;        // front-panel key pressed
      logic wdog;       // watchdog expired
      logic trig;       // trigger address accessed
      logic instr;      // reset instruction executing
      logic bp_in;      // backplane reset input asserted
   } brg_src_t;

   // outputs of the stretch counter
   typedef struct packed {
      logic active;     // stretch in progress
      logic release_p;  // one-cycle release pulse
   } brg_tmr_t;
endpackage

// file: core/brg_stretch.sv
// module: retriggerable reset stretcher counting board clock cycles
`timescale 1ns/1ps
module brg_stretch #(
   parameter int unsigned CYCLES = brg_pkg::RESET_CYCLES
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // control
   input  wire logic          hold,     // level: keep counter loaded
   input  wire logic          trigger,  // pulse: restart full period
   // status
   output brg_pkg::brg_tmr_t  tmr
);
   logic [31:0] cnt_q;    // cycles still to run
   logic        act_q;    // stretch active
   logic        rel_q;    // release pulse

   // any hold or trigger reloads, so a fresh full period follows
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 32'(CYCLES - 1); // a full period runs after release too
         act_q <= 1'b1;   // come up in reset until one period has run
         rel_q <= 1'b0;
      end else if (hold || trigger) begin
         cnt_q <= 32'(CYCLES - 1);
         act_q <= 1'b1;
         rel_q <= 1'b0;
      end else if (cnt_q != 32'h0000_0000) begin
         cnt_q <= cnt_q - 32'h0000_0001;
         rel_q <= 1'b0;
      end else begin
         rel_q <= act_q;  // single pulse on the clock edge of release
         act_q <= 1'b0;
      end
   end

   assign tmr.active    = act_q;
   assign tmr.release_p = rel_q;
endmodule

// file: core/brg_top.sv
// module: board reset generator top, sources, stretchers, boot map and register port
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module brg_top #(
   parameter int unsigned RESET_CYCLES = brg_pkg::RESET_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // asynchronous reset sources and processor halt state from pins
   input  wire logic        volt_low,          // supply monitor: below threshold
   input  wire logic        key_n,             // front-panel reset key, low when pressed
   input  wire logic        wdog_expire,       // watchdog timeout level
   input  wire logic        trig_access,       // processor cycle to trigger address
   input  wire logic        reset_instr,       // processor reset instruction active
   input  wire logic        bp_reset_in_n,     // backplane system reset input
   input  wire logic        processor_halted,  // processor halt state
   // configuration switches
   input  wire logic        sysreset_output_enable_switch,
   input  wire logic        sysreset_input_enable_switch,
   // processor address snoop
   input  wire logic [31:0] cpu_addr,          // processor address
   input  wire logic        cpu_read,          // processor read strobe
   input  wire logic        bridge_access,     // access to a bus bridge register
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   // reset outputs
   output logic             board_reset_n,     // to on-board modules
   output logic             cpu_reset_n,       // to the processor
   output logic             bp_reset_out,      // enable of backplane reset driver
   output logic             bp_reset_out_oe_n, // low while driving the line
   // memory map and indicator
   output logic             boot_map,          // boot memory answers at zero
   output logic             vec_fetch,         // boot vector read in progress
   output logic             led_red,
   output logic             led_green
);
   // two-flop synchronisers for pin inputs
   logic [6:0] s1_q;      // first stage, read only by second stage
   logic [6:0] s2_q;      // second stage, safe to use
   logic [6:0] pins;      // raw pin vector, active high
   brg_pkg::brg_src_t src;
   brg_pkg::brg_src_t src_prev_q;  // for edge detection

   assign pins = {processor_halted, ~bp_reset_in_n, reset_instr, trig_access,
                  wdog_expire, ~key_n, volt_low};

   // pins cross into the clock domain through two flops each
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= 7'h00;
         s2_q <= 7'h00;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
      end
   end

   assign src.volt_low = s2_q[0];
   assign src.key      = s2_q[1];
   assign src.wdog     = s2_q[2];
   assign src.trig     = s2_q[3];
   assign src.instr    = s2_q[4];
   assign src.bp_in    = s2_q[5] & sysreset_input_enable_switch;

   // previous values for rising-edge events
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_prev_q <= '0;
      end else begin
         src_prev_q <= src;
      end
   end

   // rising edge of an event
   function automatic logic rise(input logic now, input logic prev);
      return now & ~prev;
   endfunction

   // register state
   logic       sw_reset_q;      // software_reset_request_bit pulse
   logic       wdog_flag_q;     // watchdog_reset_flag
   logic [7:0] bp_ctrl_q;       // backplane_reset_control_register
   logic       wdog_event;
   logic       sw_write;

   assign sw_write   = reg_wr && (reg_addr == brg_pkg::ADDR_MCR) && reg_wdata[brg_pkg::MCR_SW_RESET_BIT];
   assign wdog_event = rise(src.wdog, src_prev_q.wdog) | sw_reset_q;

   // software reset bit self clears after one cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sw_reset_q <= 1'b0;
      end else begin
         sw_reset_q <= sw_write;
      end
   end

   // watchdog flag: set beats clear; the flag survives the board reset it causes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wdog_flag_q <= 1'b0;
      end else if (wdog_event) begin
         wdog_flag_q <= 1'b1;
      end else if (reg_wr && reg_addr == brg_pkg::ADDR_STATUS && reg_wdata[brg_pkg::ST_WDOG_BIT]) begin
         wdog_flag_q <= 1'b0;
      end
   end

   // backplane control register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bp_ctrl_q <= brg_pkg::BP_CTRL_RESET;
      end else if (reg_wr && reg_addr == brg_pkg::ADDR_BP_CTRL) begin
         bp_ctrl_q <= reg_wdata;
      end
   end

   // trigger classes
   logic local_trig;      // key, trigger address, watchdog, software, supply-low edge
   logic instr_trig;      // reset instruction edge
   assign local_trig = rise(src.key, src_prev_q.key)
                     | rise(src.trig, src_prev_q.trig)
                     | wdog_event
                     | rise(src.volt_low, src_prev_q.volt_low);
   assign instr_trig = rise(src.instr, src_prev_q.instr);

   // main board stretcher: supply, local, instruction and backplane sources ORed
   brg_pkg::brg_tmr_t main_tmr;
   brg_stretch #(.CYCLES(RESET_CYCLES)) u_main (
      .clk     (clk),
      .rst     (rst),
      .hold    (src.volt_low | src.bp_in),
      .trigger (local_trig | instr_trig),
      .tmr     (main_tmr)
   );

   // instruction reset tracking and processor lockout
   logic instr_q;         // current reset came from the instruction only
   logic lock_q;          // processor held out of reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         instr_q <= 1'b0;
         lock_q  <= 1'b0;
      end else if (local_trig || src.volt_low) begin
         instr_q <= 1'b0;          // a local reset resets the processor too
         lock_q  <= 1'b0;
      end else if (instr_trig) begin
         instr_q <= 1'b1;
      end else if (!main_tmr.active) begin
         instr_q <= 1'b0;
         lock_q  <= 1'b0;
      end else if (instr_q && src.bp_in) begin
         lock_q  <= 1'b1;
      end
   end

   // backplane output cause and its own 200 ms stretch
   logic bp_cause;
   brg_pkg::brg_tmr_t bp_tmr;
   assign bp_cause = (sysreset_output_enable_switch
                      && (src.volt_low || (main_tmr.active && !instr_q && !src.bp_in)))
                   || (instr_q && main_tmr.active && bp_ctrl_q[brg_pkg::BP_INSTR_EN_BIT]);
   brg_stretch #(.CYCLES(RESET_CYCLES)) u_bp (
      .clk     (clk),
      .rst     (rst),
      .hold    (bp_cause),
      .trigger (1'b0),
      .tmr     ()
   );
   // the second stretcher's status is rebuilt locally to keep outputs registered
   logic bp_hold_q;
   logic [31:0] bp_cnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bp_cnt_q  <= 32'h0000_0000;
         bp_hold_q <= 1'b0;
      end else if (bp_cause) begin
         bp_cnt_q  <= 32'(RESET_CYCLES - 1);
         bp_hold_q <= 1'b1;
      end else if (bp_cnt_q != 32'h0000_0000) begin
         bp_cnt_q  <= bp_cnt_q - 32'h0000_0001;
      end else begin
         bp_hold_q <= 1'b0;
      end
   end
   assign bp_tmr.active    = bp_hold_q;
   assign bp_tmr.release_p = 1'b0;

   // boot map: set by any reset, cleared by bridge register access
   logic boot_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         boot_q <= 1'b1;
      end else if (main_tmr.active) begin
         boot_q <= 1'b1;
      end else if (bridge_access) begin
         boot_q <= 1'b0;
      end
   end

   // count the first two processor reads after release: stack pointer, program counter
   logic [1:0] vec_cnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vec_cnt_q <= 2'h0;
      end else if (main_tmr.active && !instr_q) begin
         vec_cnt_q <= 2'h2;
      end else if (cpu_read && vec_cnt_q != 2'h0
                   && (cpu_addr == brg_pkg::VEC_ADDR_ISP || cpu_addr == brg_pkg::VEC_ADDR_IPC)) begin
         vec_cnt_q <= vec_cnt_q - 2'h1;
      end
   end

   // registered outputs; board and processor resets released on one edge, backplane output after its own stretch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         board_reset_n     <= 1'b0;
         cpu_reset_n       <= 1'b0;
         bp_reset_out      <= 1'b0;
         bp_reset_out_oe_n <= 1'b1;
         boot_map          <= 1'b1;
         vec_fetch         <= 1'b0;
         led_red           <= 1'b1;
         led_green         <= 1'b0;
      end else begin
         board_reset_n     <= ~main_tmr.active;
         cpu_reset_n       <= ~(main_tmr.active & ~instr_q & ~lock_q);
         bp_reset_out      <= bp_tmr.active;
         bp_reset_out_oe_n <= ~bp_tmr.active;
         boot_map          <= boot_q;
         vec_fetch         <= (vec_cnt_q != 2'h0) & boot_q;
         led_red           <= main_tmr.active;
         led_green         <= ~main_tmr.active & ~src_prev_q.bp_in & ~s2_q[6];
      end
   end

   // register read mux, data in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= brg_pkg::DATA_ZERO;
      end else if (reg_rd) begin
         unique case (reg_addr)
            brg_pkg::ADDR_MCR:     reg_rdata <= brg_pkg::DATA_ZERO;
            brg_pkg::ADDR_STATUS:  reg_rdata <= {3'h0, bp_hold_q, lock_q, boot_q, main_tmr.active, wdog_flag_q};
            brg_pkg::ADDR_BP_CTRL: reg_rdata <= bp_ctrl_q;
            default:               reg_rdata <= brg_pkg::DATA_ZERO; // unmapped reads zero
         endcase
      end else begin
         reg_rdata <= brg_pkg::DATA_ZERO;
      end
   end
endmodule

// file: bench/brg_backplane.sv
// partner model: backplane reset line shared with other boards
`timescale 1ns/1ps
module brg_backplane (
   // request from another board on the line
   input  wire logic assert_req,
   // this board's open-collector driver
   input  wire logic bp_reset_out,
   input  wire logic bp_reset_out_oe_n,
   // line as seen by the receiver
   output logic      bp_reset_in_n
);
   // wired line with pull-up: any driver pulls it low, and our own driver is seen too
   assign bp_reset_in_n = !(assert_req || (bp_reset_out && !bp_reset_out_oe_n));
endmodule

// file: bench/brg_properties.sv
// checker: port properties of the board reset generator
`timescale 1ns/1ps
module brg_properties #(
   parameter int unsigned RESET_CYCLES = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // inputs watched
   input wire logic volt_low,
   input wire logic key_n,
   input wire logic reset_instr,
   input wire logic processor_halted,
   input wire logic bridge_access,
   // outputs watched
   input wire logic board_reset_n,
   input wire logic cpu_reset_n,
   input wire logic bp_reset_out,
   input wire logic bp_reset_out_oe_n,
   input wire logic boot_map,
   input wire logic led_red,
   input wire logic led_green
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   int unsigned low_q;  // cycles of board reset so far
   int unsigned bp_q;   // cycles of backplane drive so far
   // run lengths in counters, since long repetitions would unroll badly
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_q <= 0;
         bp_q  <= 0;
      end else begin
         low_q <= board_reset_n ? 0 : low_q + 1;
         bp_q  <= bp_reset_out ? bp_q + 1 : 0;
      end
   end
   volt_hold_a: assert property (volt_low [*6] |-> !board_reset_n)
      else $error("board left reset while supply low");
   stretch_len_a: assert property ($rose(board_reset_n) |-> low_q >= RESET_CYCLES)
      else $error("board reset shorter than stretch");
   key_trig_a: assert property ($fell(key_n) |-> ##[1:8] !board_reset_n)
      else $error("key press gave no reset");
   instr_cpu_a: assert property ($rose(reset_instr) && cpu_reset_n |-> cpu_reset_n [*8])
      else $error("instruction reset hit the processor");
   instr_boot_a: assert property ($rose(reset_instr) |-> ##[1:8] boot_map)
      else $error("no boot map after instruction reset");
   bp_hold_a: assert property ($fell(bp_reset_out) |-> bp_q >= RESET_CYCLES)
      else $error("backplane reset released early");
   bp_enable_a: assert property ($rose(bp_reset_out) |-> ##[0:1] !bp_reset_out_oe_n)
      else $error("backplane driver not enabled");
   led_red_a: assert property (!board_reset_n [*2] |-> led_red)
      else $error("led not red in reset");
   led_halt_a: assert property (processor_halted [*4] |-> !led_green)
      else $error("led green while halted");
   boot_clear_a: assert property (bridge_access && board_reset_n |-> ##[1:2] !boot_map)
      else $error("boot map kept after bridge access");
   // main scenarios
   cover property ($rose(board_reset_n));
   cover property ($rose(bp_reset_out));
   cover property (!board_reset_n && cpu_reset_n);
endmodule
bind brg_top brg_properties #(.RESET_CYCLES(RESET_CYCLES)) brg_properties_i (
   .clk(clk), .rst(rst), .volt_low(volt_low), .key_n(key_n), .reset_instr(reset_instr),
   .processor_halted(processor_halted), .bridge_access(bridge_access), .board_reset_n(board_reset_n),
   .cpu_reset_n(cpu_reset_n), .bp_reset_out(bp_reset_out), .bp_reset_out_oe_n(bp_reset_out_oe_n),
   .boot_map(boot_map), .led_red(led_red), .led_green(led_green));

// file: bench/tb.sv
// testbench: reset sources, stretch, backplane, boot map and register port
`timescale 1ns/1ps
module tb;
   localparam int unsigned RC = 20;  // short stretch keeps the run brief
   // design inputs
   logic clk, rst, volt_low, key_n, wdog_expire, trig_access, reset_instr, processor_halted;
   logic out_sw, in_sw, cpu_read, bridge_access, reg_wr, reg_rd, bp_req, bp_reset_in_n;
   logic [31:0] cpu_addr;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rd;
   // design outputs
   logic board_reset_n, cpu_reset_n, bp_reset_out, bp_reset_out_oe_n, boot_map, vec_fetch, led_red, led_green;
   // model state and counters
   int n_fail, checked, low, s, h, e;
   logic cpu_lo, bp_seen, ctl;

   brg_top #(.RESET_CYCLES(RC)) brg_top_i (.clk(clk), .rst(rst), .volt_low(volt_low), .key_n(key_n),
      .wdog_expire(wdog_expire), .trig_access(trig_access), .reset_instr(reset_instr),
      .bp_reset_in_n(bp_reset_in_n), .processor_halted(processor_halted),
      .sysreset_output_enable_switch(out_sw), .sysreset_input_enable_switch(in_sw), .cpu_addr(cpu_addr),
      .cpu_read(cpu_read), .bridge_access(bridge_access), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .board_reset_n(board_reset_n),
      .cpu_reset_n(cpu_reset_n), .bp_reset_out(bp_reset_out), .bp_reset_out_oe_n(bp_reset_out_oe_n),
      .boot_map(boot_map), .vec_fetch(vec_fetch), .led_red(led_red), .led_green(led_green));
   brg_backplane brg_backplane_i (.assert_req(bp_req), .bp_reset_out(bp_reset_out),
      .bp_reset_out_oe_n(bp_reset_out_oe_n), .bp_reset_in_n(bp_reset_in_n));

   // 20 MHz board clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // hang guard, far beyond the few thousand cycles the tests need
   initial begin
      #2_000_000;
      n_fail++;
      final_report();
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // register port cycles, one strobe cycle then a gap
   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk);
   endtask
   // processor vector read or bridge access, one strobe cycle
   task automatic cpu_pulse(input logic [31:0] a, input logic br);
      cpu_addr <= a;
      cpu_read <= !br;
      bridge_access <= br;
      @(posedge clk);
      cpu_read <= 1'b0;
      bridge_access <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   // source pins: 0 supply, 1 key, 2 watchdog, 3 trigger, 5 instruction, other backplane
   task automatic drive(input int src, input logic v);
      case (src)
         0: volt_low <= v;
         1: key_n <= !v;
         2: wdog_expire <= v;
         3: trig_access <= v;
         5: reset_instr <= v;
         default: bp_req <= v;
      endcase
   endtask
   task automatic fire(input int src, input int len);
      if (src == 4) begin
         reg_write(brg_pkg::ADDR_MCR, 8'h01);
      end else begin
         drive(src, 1'b1);
         repeat (len) @(posedge clk);
         drive(src, 1'b0);
         @(posedge clk);
      end
   endtask
   // counts reset cycles until board and backplane are both quiet
   task automatic watch();
      int t;
      low = 0;
      cpu_lo = 0;
      bp_seen = 0;
      for (t = 0; t < 400; t++) begin
         @(posedge clk);
         #1;
         if (!board_reset_n) low++;
         if (!cpu_reset_n) cpu_lo = 1;
         if (bp_reset_out) bp_seen = 1;
         if (low > 0 && board_reset_n && !bp_reset_out) break;
      end
      @(posedge clk);
   endtask

   initial begin
      {rst, key_n} = 2'b11;
      {volt_low, wdog_expire, trig_access, reset_instr, processor_halted, out_sw, in_sw} = 7'h00;
      {cpu_read, bridge_access, reg_wr, reg_rd, bp_req, cpu_addr, reg_addr, reg_wdata} = '0;
      n_fail = 0;
      checked = 0;
      void'($urandom(17));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      watch();
      chk(low >= RC, 1);
      reg_read(4'($urandom_range(15, 3)), rd);
      chk(rd, 8'h00);
      for (s = 0; s < 6; s++) begin
         h = $urandom_range(8, 1);
         ctl = 1'($urandom_range(1, 0));
         out_sw <= (s == 5) ? 1'b0 : 1'($urandom_range(1, 0));
         processor_halted <= 1'($urandom_range(1, 0));
         reg_write(brg_pkg::ADDR_BP_CTRL, {7'h00, ctl});
         reg_read(brg_pkg::ADDR_BP_CTRL, rd);
         chk(rd, {7'h00, ctl});
         fork
            begin
               fire(s, h);
               if (s == 0) begin
                  repeat (10) @(posedge clk);
                  fire(0, h);
               end
            end
            watch();
         join
         // model: stretch follows the last supply-low sample, 2h+10 cycles after the first
         e = RC + ((s == 0) ? 2 * h + 10 : 0);
         chk(low >= e, 1);
         chk(cpu_lo, s != 5);
         chk(bp_seen, (s == 5) ? ctl : out_sw);
         chk({led_red, led_green}, {1'b0, !processor_halted});
         chk(boot_map, 1);
         reg_read(brg_pkg::ADDR_STATUS, rd);
         chk(rd, 8'h04 | {7'h00, 1'(s == 2 || s == 4)});
         reg_write(brg_pkg::ADDR_STATUS, 8'h01);
         if (s != 5) chk(vec_fetch, 1);
         cpu_pulse(brg_pkg::VEC_ADDR_ISP, 1'b0);
         cpu_pulse(brg_pkg::VEC_ADDR_IPC, 1'b0);
         chk(vec_fetch, 0);
         cpu_pulse(32'h0000_0000, 1'b1);
         chk(boot_map, 0);
      end
      // backplane input: honoured, ignored, then during an instruction reset
      out_sw <= 1'b0;
      reg_write(brg_pkg::ADDR_BP_CTRL, 8'h00);
      for (s = 0; s < 3; s++) begin
         in_sw <= (s != 1);
         fork
            begin
               if (s == 2) begin
                  fire(5, 1);
                  repeat (3) @(posedge clk);
               end
               fire(6, 30);
            end
            watch();
         join
         chk(low >= 29 + RC, s != 1);
         chk(cpu_lo, s == 0);
      end
      final_report();
   end
endmodule
